// file: include/dram_ctl_pkg.sv
// package: shared constants and carrier structs for the 1k x 1 dynamic ram controller
package dram_ctl_pkg;

  // array geometry
  localparam int ROW_BITS  = 5;
  localparam int COL_BITS  = 5;
  localparam int ADDR_BITS = ROW_BITS + COL_BITS;
  localparam int NUM_ROWS  = 32;

  // clock and retention interval
  localparam int CLK_PERIOD_NS      = 20;
  localparam int RETENTION_STD_NS   = 2000000;  // 2 ms
  localparam int RETENTION_FAST_NS  = 1000000;  // 1 ms
  // cycles between row refreshes, rounded down so the whole sweep fits
  localparam int REFRESH_GAP_STD    = RETENTION_STD_NS / (CLK_PERIOD_NS * NUM_ROWS);
  localparam int REFRESH_GAP_FAST   = RETENTION_FAST_NS / (CLK_PERIOD_NS * NUM_ROWS);

  // strobe phase lengths in clock cycles
  localparam int ADDR_SETUP_CYC     = 1;   // address settles before strobes move
  localparam int PRE_LEAD_CYC       = 2;   // precharge low before chip select falls
  localparam int OVERLAP_CYC        = 3;   // precharge and chip select both low
  localparam int ACCESS_CYC         = 4;   // chip select low after precharge rises
  localparam int WRITE_CYC          = 3;   // read/write low in write portion
  localparam int RECOVER_CYC        = 2;   // all strobes idle between cycles
  localparam int CNT_W              = 4;

  // reset values of pins
  localparam logic PIN_CS_N_RST     = 1'b1;
  localparam logic PIN_PRE_RST      = 1'b1;
  localparam logic PIN_RW_RST       = 1'b1;

  // operation requested by the user
  typedef enum logic [1:0] {
    OP_READ,
    OP_WRITE,
    OP_RMW
  } op_e;

  // user request carrier
  typedef struct packed {
    op_e                    op;
    logic [ADDR_BITS-1:0]   addr;
    logic                   wdata;
  } req_s;

  // pins toward the memory
  typedef struct packed {
    logic [ADDR_BITS-1:0]   cell_address_bus;
    logic                   chip_sel_n;
    logic                   precharge_n;
    logic                   read_write;
    logic                   write_bit_in;
  } pins_s;

endpackage

// file: design/refresh_timer.sv
// row refresh pacer: row counter and interval timer for the controller
`timescale 1ns/1ps

module refresh_timer #(
  parameter int GAP_CYC = dram_ctl_pkg::REFRESH_GAP_STD
) (
  // clock and reset
  input  wire logic                              i_clk,
  input  wire logic                              i_reset,
  // handshake with the sequencer
  input  wire logic                              i_done,
  output logic                                   o_due,
  output logic [dram_ctl_pkg::ROW_BITS-1:0]      o_row
);

  logic [31:0]                         tick_ff;
  logic                                due_ff;
  logic [dram_ctl_pkg::ROW_BITS-1:0]   row_ff;
  wire                                 tick_end = (tick_ff == 32'(GAP_CYC - 1));

  // a due request persists until served; the timer keeps running so the
  // sweep period stays fixed even when normal traffic delays a refresh
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      tick_ff <= 32'h0;
      due_ff  <= 1'b0;
      row_ff  <= '0;
    end else begin
      tick_ff <= tick_end ? 32'h0 : tick_ff + 32'h1;
      due_ff  <= tick_end | (due_ff & ~i_done);  // set wins over clear
      if (i_done) begin
        row_ff <= row_ff + {{(dram_ctl_pkg::ROW_BITS-1){1'b0}}, 1'b1};
      end
    end
  end

  assign o_due = due_ff;
  assign o_row = row_ff;

endmodule

// file: design/dram_ctl.sv
// host-side sequencer driving a 1k x 1 dynamic ram through its strobe pins
`timescale 1ns/1ps
//
// Summary of operation
// - low five bits row, high five column
// - every row addressed within retention interval
// - address stable across strobe and data edges
// - chip select low through access
// - precharge low first, overlaps chip select
// - overlap length bounded min and max
// - read/write low writes, high reads
// - read sampled just before chip select rises
// - rmw sampled before read/write falls
//
////////////////////////////////////////////////////////////////////////////////

module dram_ctl #(
  parameter bit FAST_PART = 1'b0,
  parameter int GAP_CYC   = FAST_PART ? dram_ctl_pkg::REFRESH_GAP_FAST
                                      : dram_ctl_pkg::REFRESH_GAP_STD
) (
  // clock and reset
  input  wire logic                  I_REF_CLK,
  input  wire logic                  I_RESET,
  // user request
  input  wire logic                  I_REQ_VALID,
  input  wire dram_ctl_pkg::req_s    I_REQ,
  output logic                       O_REQ_READY,
  // user answer
  output logic                       O_RD_VALID,
  output logic                       O_RD_DATA,
  // memory pins
  output dram_ctl_pkg::pins_s        O_PINS,
  input  wire logic                  I_DATA_OUT_N
);

  // phase counter width kept as a local name so the size casts below stay plain
  localparam int CNT_W = dram_ctl_pkg::CNT_W;

  ////////////////////////////////////////////////////////////////////////////
  // state
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_SETUP,
    ST_PRE,
    ST_OVERLAP,
    ST_ACCESS,
    ST_WRITE,
    ST_HOLD,
    ST_RECOVER
  } state_e;

  state_e                               state_ff, nxt_state;
  logic [dram_ctl_pkg::CNT_W-1:0]       cnt_ff,   nxt_cnt;
  dram_ctl_pkg::pins_s                  pins_ff,  nxt_pins;
  dram_ctl_pkg::op_e                    op_ff,    nxt_op;
  logic                                 refr_ff,  nxt_refr;
  logic                                 rdv_ff,   nxt_rdv;
  logic                                 rdd_ff,   nxt_rdd;

  logic                                 ref_due;
  logic [dram_ctl_pkg::ROW_BITS-1:0]    ref_row;
  logic                                 ref_done;

  ////////////////////////////////////////////////////////////////////////////
  // refresh pacing
  refresh_timer #(
    .GAP_CYC (GAP_CYC)
  ) u_refresh (
    .i_clk   (I_REF_CLK),
    .i_reset (I_RESET),
    .i_done  (ref_done),
    .o_due   (ref_due),
    .o_row   (ref_row)
  );

  // decode of phase ends and selection of the next access
  wire cnt_zero   = (cnt_ff == '0);
  wire idle       = (state_ff == ST_IDLE);
  wire take_ref   = idle & ref_due;  // refresh has priority
  wire take_user  = idle & ~ref_due & I_REQ_VALID;
  wire is_wr      = (op_ff != dram_ctl_pkg::OP_READ);
  // refresh row in the low five bits with column zero
  wire [dram_ctl_pkg::ADDR_BITS-1:0] ref_addr =
    {{dram_ctl_pkg::COL_BITS{1'b0}}, ref_row};

  assign ref_done    = (state_ff == ST_RECOVER) & cnt_zero & refr_ff;
  assign O_REQ_READY = idle & ~ref_due;

  ////////////////////////////////////////////////////////////////////////////
  // sequencer next state
  always_comb begin
    nxt_state = state_ff;
    nxt_cnt   = cnt_zero ? '0 : cnt_ff - CNT_W'(1);
    nxt_pins  = pins_ff;
    nxt_op    = op_ff;
    nxt_refr  = refr_ff;
    nxt_rdv   = 1'b0;
    nxt_rdd   = rdd_ff;
    unique case (state_ff)
      ST_IDLE: begin
        if (take_ref) begin
          // a refresh is a plain read of the row, nothing written back
          nxt_pins.cell_address_bus = ref_addr;
          nxt_op    = dram_ctl_pkg::OP_READ;
          nxt_refr  = 1'b1;
          nxt_state = ST_SETUP;
          nxt_cnt   = CNT_W'(dram_ctl_pkg::ADDR_SETUP_CYC - 1);
        end else if (take_user) begin
          nxt_pins.cell_address_bus = I_REQ.addr;
          nxt_pins.write_bit_in     = I_REQ.wdata;
          nxt_op    = I_REQ.op;
          nxt_refr  = 1'b0;
          nxt_state = ST_SETUP;
          nxt_cnt   = CNT_W'(dram_ctl_pkg::ADDR_SETUP_CYC - 1);
        end
      end
      ST_SETUP: begin
        if (cnt_zero) begin
          nxt_pins.precharge_n = 1'b0;  // precharge opens the cycle
          nxt_state = ST_PRE;
          nxt_cnt   = CNT_W'(dram_ctl_pkg::PRE_LEAD_CYC - 1);
        end
      end
      ST_PRE: begin
        if (cnt_zero) begin
          nxt_pins.chip_sel_n = 1'b0;
          nxt_state = ST_OVERLAP;
          nxt_cnt   = CNT_W'(dram_ctl_pkg::OVERLAP_CYC - 1);
        end
      end
      ST_OVERLAP: begin
        // fixed count keeps overlap inside its window
        if (cnt_zero) begin
          nxt_pins.precharge_n = 1'b1;
          nxt_state = ST_ACCESS;
          nxt_cnt   = CNT_W'(dram_ctl_pkg::ACCESS_CYC - 1);
        end
      end
      ST_ACCESS: begin
        if (cnt_zero) begin
          // device output is the complement of the stored bit
          nxt_rdd = ~I_DATA_OUT_N;
          nxt_rdv = ~refr_ff & (op_ff != dram_ctl_pkg::OP_WRITE);
          if (is_wr) begin
            // sampled before read/write falls
            nxt_pins.read_write = 1'b0;  // low means write
            nxt_state = ST_WRITE;
            nxt_cnt   = CNT_W'(dram_ctl_pkg::WRITE_CYC - 1);
          end else begin
            // sampled on the last cycle before chip select rises
            nxt_pins.chip_sel_n = 1'b1;
            nxt_state = ST_RECOVER;
            nxt_cnt   = CNT_W'(dram_ctl_pkg::RECOVER_CYC - 1);
          end
        end
      end
      ST_WRITE: begin
        // data-in held steady while the cell takes it
        if (cnt_zero) begin
          nxt_pins.read_write = 1'b1;
          nxt_state = ST_HOLD;
        end
      end
      ST_HOLD: begin
        // read/write rises one cycle before chip select so edges never coincide
        nxt_pins.chip_sel_n = 1'b1;
        nxt_state = ST_RECOVER;
        nxt_cnt   = CNT_W'(dram_ctl_pkg::RECOVER_CYC - 1);
      end
      ST_RECOVER: begin
        // address holds here; it only changes in ST_IDLE, after every strobe is idle
        if (cnt_zero) begin
          nxt_state = ST_IDLE;
        end
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers
  always_ff @(posedge I_REF_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      state_ff <= ST_IDLE;
      cnt_ff   <= '0;
      pins_ff  <= '{cell_address_bus: '0,
                     chip_sel_n:       dram_ctl_pkg::PIN_CS_N_RST,
                     precharge_n:      dram_ctl_pkg::PIN_PRE_RST,
                     read_write:       dram_ctl_pkg::PIN_RW_RST,
                     write_bit_in:     1'b0};
      op_ff    <= dram_ctl_pkg::OP_READ;
      refr_ff  <= 1'b0;
      rdv_ff   <= 1'b0;
      rdd_ff   <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff   <= nxt_cnt;
      pins_ff  <= nxt_pins;
      op_ff    <= nxt_op;
      refr_ff  <= nxt_refr;
      rdv_ff   <= nxt_rdv;
      rdd_ff   <= nxt_rdd;
    end
  end

  // outputs; data out is only trusted while our chip select is low
  assign O_PINS      = pins_ff;
  assign O_RD_VALID  = rdv_ff;
  assign O_RD_DATA   = rdd_ff;

endmodule

// file: test/dram_ctl_chk.sv
// checker of strobe order and read sampling on the controller pins
`timescale 1ns/1ps

module dram_ctl_chk #(
  parameter int GAP_CYC = 40
) (
  // clock and reset
  input wire logic                I_REF_CLK,
  input wire logic                I_RESET,
  // user side
  input wire logic                I_REQ_VALID,
  input wire dram_ctl_pkg::req_s  I_REQ,
  input wire logic                O_REQ_READY,
  input wire logic                O_RD_VALID,
  input wire logic                O_RD_DATA,
  // memory pins
  input wire dram_ctl_pkg::pins_s O_PINS,
  input wire logic                I_DATA_OUT_N
);
  default clocking @(posedge I_REF_CLK); endclocking
  default disable iff (I_RESET);
  // named views of the pin bundle
  wire cs_n = O_PINS.chip_sel_n;
  wire pre  = O_PINS.precharge_n;
  wire rw   = O_PINS.read_write;
  wire din  = O_PINS.write_bit_in;
  int unsigned idle_ff;
  // cycles with chip select high; a lost refresh shows up as a long gap
  always_ff @(posedge I_REF_CLK or posedge I_RESET) begin
    if (I_RESET) idle_ff <= 0;
    else idle_ff <= cs_n ? idle_ff + 1 : 0;
  end
  ////////////////////////////////////////////////////////////////////////////
  property p_addr; ($changed(cs_n) || (!cs_n && ($changed(rw) || $changed(din))))
    |-> $stable(O_PINS.cell_address_bus); endproperty
  a_addr: assert property (p_addr) else $error("address moved");
  property p_lead; $fell(cs_n) |-> !pre && !$past(pre, 2); endproperty
  a_lead: assert property (p_lead) else $error("precharge lead short");
  property p_ovl; $fell(cs_n) |-> !pre [*3] ##1 pre; endproperty
  a_ovl: assert property (p_ovl) else $error("overlap length wrong");
  property p_acc; $rose(pre) |-> !cs_n [*4]; endproperty
  a_acc: assert property (p_acc) else $error("select dropped early");
  property p_rwcs; !rw |-> !cs_n && pre; endproperty
  a_rwcs: assert property (p_rwcs) else $error("write outside access");
  property p_rd; O_RD_VALID && $rose(cs_n) |-> O_RD_DATA == !$past(I_DATA_OUT_N); endproperty
  a_rd: assert property (p_rd) else $error("read sample wrong");
  property p_rmw; O_RD_VALID && $fell(rw) |-> O_RD_DATA == !$past(I_DATA_OUT_N); endproperty
  a_rmw: assert property (p_rmw) else $error("modify sample wrong");
  property p_gap; idle_ff < GAP_CYC + 20; endproperty
  a_gap: assert property (p_gap) else $error("refresh too late");
endmodule

bind dram_ctl dram_ctl_chk #(.GAP_CYC(GAP_CYC)) u_chk (.I_REF_CLK(I_REF_CLK),
  .I_RESET(I_RESET), .I_REQ_VALID(I_REQ_VALID), .I_REQ(I_REQ), .O_REQ_READY(O_REQ_READY),
  .O_RD_VALID(O_RD_VALID), .O_RD_DATA(O_RD_DATA), .O_PINS(O_PINS), .I_DATA_OUT_N(I_DATA_OUT_N));

// file: test/dram_model.sv
// behavioural 1k x 1 dynamic ram answering the controller strobes
`timescale 1ns/1ps

module dram_model (
  // clock and pins
  input  wire logic                 i_clk,
  input  wire dram_ctl_pkg::pins_s  i_pins,
  output logic                      o_data_out_n
);
  logic [1023:0] cell_ff;         // 32 x 32, row in the low five bits
  logic          junk_ff = 1'h0;
  // store while selected with read/write low; a read leaves cells alone
  always_ff @(posedge i_clk) begin
    junk_ff <= ~junk_ff;
    if (!i_pins.chip_sel_n && !i_pins.read_write) begin
      cell_ff[i_pins.cell_address_bus] <= i_pins.write_bit_in;
    end
  end
  // deselected output toggles every cycle so a stray sample never holds a steady value
  assign o_data_out_n = i_pins.chip_sel_n ? junk_ff
                      : ~cell_ff[i_pins.cell_address_bus];
endmodule

// file: test/dram_ctl_bench.sv
// self-checking bench: user requests against a behavioural memory
`timescale 1ns/1ps

module dram_ctl_bench;
  localparam int GAP = 40;  // short refresh spacing keeps the run brief
  typedef struct packed {
    dram_ctl_pkg::op_e op;
    logic [9:0]        a;
    logic              d;
    logic              q;
  } row_s;
  // writes, reads back, then one modify cycle and a check read
  localparam row_s ROWS [8] = '{
    '{dram_ctl_pkg::OP_WRITE, 10'h3FF, 1'h1, 1'h0},
    '{dram_ctl_pkg::OP_WRITE, 10'h01F, 1'h1, 1'h0},
    '{dram_ctl_pkg::OP_WRITE, 10'h3E0, 1'h0, 1'h0},
    '{dram_ctl_pkg::OP_READ,  10'h3FF, 1'h0, 1'h1},
    '{dram_ctl_pkg::OP_READ,  10'h3E0, 1'h0, 1'h0},
    '{dram_ctl_pkg::OP_READ,  10'h01F, 1'h0, 1'h1},
    '{dram_ctl_pkg::OP_RMW,   10'h3FF, 1'h0, 1'h1},
    '{dram_ctl_pkg::OP_READ,  10'h3FF, 1'h0, 1'h0}};
  logic                I_REF_CLK   = 1'h0;
  logic                I_RESET     = 1'h1;
  logic                I_REQ_VALID = 1'h0;
  dram_ctl_pkg::req_s  I_REQ       = '0;
  logic                O_REQ_READY, O_RD_VALID, O_RD_DATA, data_n, q;
  dram_ctl_pkg::pins_s O_PINS;
  logic [9:0]          r0, r1;
  int                  errors = 0, check_count = 0, cyc = 0;

  dram_ctl #(.GAP_CYC(GAP)) dut (.I_REF_CLK(I_REF_CLK), .I_RESET(I_RESET),
    .I_REQ_VALID(I_REQ_VALID), .I_REQ(I_REQ), .O_REQ_READY(O_REQ_READY),
    .O_RD_VALID(O_RD_VALID), .O_RD_DATA(O_RD_DATA), .O_PINS(O_PINS), .I_DATA_OUT_N(data_n));
  dram_model u_mem (.i_clk(I_REF_CLK), .i_pins(O_PINS), .o_data_out_n(data_n));

  always #10 I_REF_CLK = ~I_REF_CLK;
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [9:0] ex, input logic [9:0] got);
    check_count++;
    if (got !== ex) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", nm, ex, got);
    end
  endtask
  // hold the request until taken, then collect any read answer
  task automatic req(input row_s r, output logic rd);
    @(negedge I_REF_CLK);
    I_REQ_VALID = 1'h1;
    I_REQ = '{r.op, r.a, r.d};
    while (O_REQ_READY !== 1'h1) @(negedge I_REF_CLK);
    @(negedge I_REF_CLK);
    I_REQ_VALID = 1'h0;
    @(negedge I_REF_CLK);
    chk("address", r.a, O_PINS.cell_address_bus);
    rd = 'x;
    repeat (12) begin
      @(negedge I_REF_CLK);
      if (O_RD_VALID === 1'h1) rd = O_RD_DATA;
    end
  endtask
  // address of the next access that starts while no user request waits
  task automatic next_access(output logic [9:0] a);
    logic p;
    p = 1'h0;
    a = 'x;
    repeat (200) begin
      @(negedge I_REF_CLK);
      if (p === 1'h1 && O_PINS.chip_sel_n === 1'h0) begin
        a = O_PINS.cell_address_bus;
        return;
      end
      p = O_PINS.chip_sel_n;
    end
  endtask
  task automatic close_out;
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // a hang counts as a mismatch
  always @(posedge I_REF_CLK) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      close_out();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20) @(posedge I_REF_CLK);
    @(negedge I_REF_CLK);
    chk("select in reset", dram_ctl_pkg::PIN_CS_N_RST, O_PINS.chip_sel_n);
    chk("precharge in reset", dram_ctl_pkg::PIN_PRE_RST, O_PINS.precharge_n);
    chk("ready in reset", 10'h001, O_REQ_READY);
    I_RESET = 1'h0;
    for (int i = 0; i < 8; i++) begin
      req(ROWS[i], q);
      if (ROWS[i].op != dram_ctl_pkg::OP_WRITE) chk("read data", ROWS[i].q, q);
    end
    next_access(r0);
    next_access(r1);
    chk("refresh column", 10'h000, {r0[9:5], r1[9:5]});
    chk("refresh row", {5'h00, r0[4:0] + 5'h01}, {5'h00, r1[4:0]});
    // reset in mid access must drop the strobes and keep the cells
    @(negedge I_REF_CLK);
    I_REQ_VALID = 1'h1;
    I_REQ = '{dram_ctl_pkg::OP_READ, 10'h01F, 1'h0};
    while (O_REQ_READY !== 1'h1) @(negedge I_REF_CLK);
    @(negedge I_REF_CLK);
    I_REQ_VALID = 1'h0;
    // five cycles after the take the select is low, so the abort really cuts an access
    repeat (5) @(negedge I_REF_CLK);
    chk("select in access", 10'h000, O_PINS.chip_sel_n);
    chk("ready while busy", 10'h000, O_REQ_READY);
    I_RESET = 1'h1;
    @(negedge I_REF_CLK);
    chk("select after abort", dram_ctl_pkg::PIN_CS_N_RST, O_PINS.chip_sel_n);
    chk("write line after abort", dram_ctl_pkg::PIN_RW_RST, O_PINS.read_write);
    I_RESET = 1'h0;
    req(ROWS[5], q);
    chk("read after abort", 10'h001, q);
    close_out();
  end
endmodule
